/* hdl/upbc_bus_divider.sv */
// Peripheral bus clock divider with settle flag
module upbc_bus_divider #(
	parameter int DIV_WIDTH = 7
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic enable,
	input wire logic [DIV_WIDTH-1:0] divisor,
	output logic tick,
	output logic ready
);
	logic [DIV_WIDTH-1:0] count_reg;
	logic [DIV_WIDTH-1:0] lastDiv_reg;
	logic ready_reg;
	logic tick_reg;

	if (DIV_WIDTH < 1 || DIV_WIDTH > 16) begin : badWidth
		$error("bus divider width must be 1 to 16");
	end

	////////////////////////////////////////////////////////////////////////
	// Ratio counter, divide by divisor plus one
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			count_reg <= '0;
			tick_reg <= 1'b0;
		end else if (divisor != lastDiv_reg || count_reg >= divisor) begin
			count_reg <= '0;
			tick_reg <= enable && divisor == lastDiv_reg;
		end else begin
			count_reg <= count_reg + 1'b1;
			tick_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Settle flag drops on a change, rises after one whole new period
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			lastDiv_reg <= DIV_WIDTH'(1);
			ready_reg <= 1'b1;
		end else begin
			lastDiv_reg <= divisor;
			if (divisor != lastDiv_reg) begin
				ready_reg <= 1'b0;
			end else if (count_reg >= divisor) begin
				ready_reg <= 1'b1;
			end
		end
	end

	assign tick = tick_reg;
	assign ready = ready_reg;

	div_settle_a: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		divisor != lastDiv_reg |=> !ready ##1 (!ready || $past(count_reg >= divisor))
	) else $error("divider ready without a settled period");

endmodule : upbc_bus_divider

/* hdl/upbc_clock_control.sv */
// USB PLL control, bus dividers, slew and clock status behind an AXI4-Lite slave
`include "upbc_defs.svh"
module upbc_clock_control
	import upbc_pkg::*;
#(
	parameter int STABLE_CYCLES = `UPBC_STABLE_CYC
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire upbc_axi_req_t axiReq,
	output upbc_axi_rsp_t axiRsp,
	input wire logic [2:0] cfgOutputDividerDefault,
	input wire logic cfgUsbSourceDefault,
	input wire logic coldReset,
	input wire logic [2:0] currentOscillatorSelect,
	input wire logic [5:0] sourceRunning,
	output logic usbClockSourceSelect,
	output upbc_pll_cfg_t pllConfig,
	output logic [2:0] busClockTick
);
	if (STABLE_CYCLES < 1 || STABLE_CYCLES > 255) begin : badStable
		$error("STABLE_CYCLES must be 1 to 255");
	end

	////////////////////////////////////////////////////////////////////////
	// Helpers
	function automatic logic [31:0] mergeStrb(logic [31:0] old, logic [31:0] data,
			logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = data[b*8 +: 8];
			end
		end
		return res;
	endfunction : mergeStrb

	function automatic logic [5:0] divideBy(logic [2:0] code);
		case (code)
			3'h1: divideBy = 6'h02;
			3'h2: divideBy = 6'h04;
			3'h3: divideBy = 6'h08;
			3'h4: divideBy = 6'h10;
			3'h5: divideBy = 6'h20;
			default: divideBy = 6'h00;
		endcase
	endfunction : divideBy

	function automatic logic isReserved(logic [2:0] code);
		return divideBy(code) == 6'h00;
	endfunction : isReserved

	function automatic logic isMapped(logic [`UPBC_ADDR_W-1:0] a);
		return a == `UPBC_OFS_BUS5 || a == `UPBC_OFS_BUS6 || a == `UPBC_OFS_BUS7
			|| a == `UPBC_OFS_SLEW || a == `UPBC_OFS_STAT || a == `UPBC_OFS_USB_PHASE_LOCKED_LOOP
			|| a == `UPBC_OFS_KEY;
	endfunction : isMapped

	////////////////////////////////////////////////////////////////////////
	// Write channels
	logic awFull_reg;
	logic wFull_reg;
	logic [`UPBC_ADDR_W-1:0] awAddr_reg;
	logic [31:0] wData_reg;
	logic [3:0] wStrb_reg;
	logic bValid_reg;
	logic [1:0] bResp_reg;
	logic writeGo;

	assign writeGo = awFull_reg && wFull_reg && !bValid_reg;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			awFull_reg <= 1'b0;
			awAddr_reg <= '0;
		end else if (axiReq.awvalid && !awFull_reg && !bValid_reg) begin
			awFull_reg <= 1'b1;
			awAddr_reg <= axiReq.awaddr;
		end else if (writeGo) begin
			awFull_reg <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wFull_reg <= 1'b0;
			wData_reg <= '0;
			wStrb_reg <= '0;
		end else if (axiReq.wvalid && !wFull_reg && !bValid_reg) begin
			wFull_reg <= 1'b1;
			wData_reg <= axiReq.wdata;
			wStrb_reg <= axiReq.wstrb;
		end else if (writeGo) begin
			wFull_reg <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			bValid_reg <= 1'b0;
			bResp_reg <= `UPBC_RESP_OKAY;
		end else if (writeGo) begin
			bValid_reg <= 1'b1;
			bResp_reg <= isMapped(awAddr_reg) ? `UPBC_RESP_OKAY : `UPBC_RESP_SLVERR;
		end else if (axiReq.bready) begin
			bValid_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Unlock sequence
	logic unlocked;
	logic upllSel;
	logic upllWriteOk;

	assign upllSel = writeGo && awAddr_reg == `UPBC_OFS_USB_PHASE_LOCKED_LOOP;
	assign upllWriteOk = upllSel && unlocked
		&& currentOscillatorSelect != `UPBC_CURRENT_OSCILLATOR_SELECT_USB_PHASE_LOCKED_LOOP;

	upbc_unlock unlockSeq (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.keyWrite(writeGo && awAddr_reg == `UPBC_OFS_KEY),
		.keyData(wData_reg),
		.consume(upllSel),
		.unlocked(unlocked)
	);

	////////////////////////////////////////////////////////////////////////
	// USB PLL control, loaded from configuration words after reset release
	logic [31:0] usb_phase_locked_loop_reg;
	logic [31:0] usb_phase_locked_loop_next;
	logic initDone_reg;

	always_comb begin
		usb_phase_locked_loop_next = mergeStrb(usb_phase_locked_loop_reg, wData_reg, wStrb_reg) & `UPBC_USB_PHASE_LOCKED_LOOP_MASK;
		if (isReserved(usb_phase_locked_loop_next[`UPBC_USB_PHASE_LOCKED_LOOP_ODIV +: 3])) begin
			usb_phase_locked_loop_next[`UPBC_USB_PHASE_LOCKED_LOOP_ODIV +: 3] = usb_phase_locked_loop_reg[`UPBC_USB_PHASE_LOCKED_LOOP_ODIV +: 3];
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			usb_phase_locked_loop_reg <= `UPBC_USB_PHASE_LOCKED_LOOP_RST;
			initDone_reg <= 1'b0;
		end else if (!initDone_reg) begin
			initDone_reg <= 1'b1;
			usb_phase_locked_loop_reg[`UPBC_USB_PHASE_LOCKED_LOOP_ODIV +: 3] <= cfgOutputDividerDefault;
			usb_phase_locked_loop_reg[`UPBC_USB_PHASE_LOCKED_LOOP_SRC] <= !coldReset && cfgUsbSourceDefault;
		end else if (upllWriteOk) begin
			usb_phase_locked_loop_reg <= usb_phase_locked_loop_next;
		end
	end

	assign usbClockSourceSelect = usb_phase_locked_loop_reg[`UPBC_USB_PHASE_LOCKED_LOOP_SRC];
	assign pllConfig.multiplier = usb_phase_locked_loop_reg[`UPBC_USB_PHASE_LOCKED_LOOP_MULT +: 7];
	assign pllConfig.inputDivider = usb_phase_locked_loop_reg[`UPBC_USB_PHASE_LOCKED_LOOP_IDIV +: 3];
	assign pllConfig.inputRange = usb_phase_locked_loop_reg[`UPBC_USB_PHASE_LOCKED_LOOP_RANGE +: 3];
	assign pllConfig.outputDivideBy = divideBy(usb_phase_locked_loop_reg[`UPBC_USB_PHASE_LOCKED_LOOP_ODIV +: 3]);

	////////////////////////////////////////////////////////////////////////
	// Bus dividers; the seventh has no storage
	logic [31:0] bus5_reg;
	logic [31:0] bus6_reg;
	logic [2:0] busReady;
	logic [`UPBC_BUSDIV_W-1:0] busDivisor [3];
	logic [2:0] busOn;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			bus5_reg <= `UPBC_BUSDIV_RST & 32'h0000807F;
		end else if (writeGo && awAddr_reg == `UPBC_OFS_BUS5) begin
			bus5_reg <= mergeStrb(bus5_reg, wData_reg, wStrb_reg) & 32'h0000807F;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			bus6_reg <= `UPBC_BUSDIV_RST & 32'h0000807F;
		end else if (writeGo && awAddr_reg == `UPBC_OFS_BUS6) begin
			bus6_reg <= mergeStrb(bus6_reg, wData_reg, wStrb_reg) & 32'h0000807F;
		end
	end

	assign busDivisor[0] = bus5_reg[`UPBC_BUSDIV_W-1:0];
	assign busDivisor[1] = bus6_reg[`UPBC_BUSDIV_W-1:0];
	assign busDivisor[2] = `UPBC_BUSDIV_W'(`UPBC_BUS7_RST & 32'h0000007F);
	assign busOn = {1'b1, bus6_reg[`UPBC_BUSDIV_ON], bus5_reg[`UPBC_BUSDIV_ON]};

	for (genvar i = 0; i < 3; i++) begin : busDiv
		upbc_bus_divider #(
			.DIV_WIDTH(`UPBC_BUSDIV_W)
		) divider (
			.core_clk(core_clk),
			.rst_n(rst_n),
			.enable(busOn[i]),
			.divisor(busDivisor[i]),
			.tick(busClockTick[i]),
			.ready(busReady[i])
		);
	end

	////////////////////////////////////////////////////////////////////////
	// Slew control; busy while any divider is settling
	logic [31:0] slew_reg;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			slew_reg <= `UPBC_SLEW_RST;
		end else if (writeGo && awAddr_reg == `UPBC_OFS_SLEW) begin
			slew_reg <= mergeStrb(slew_reg, wData_reg, wStrb_reg) & `UPBC_SLEW_MASK;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Source stability counters
	logic [7:0] stableCount_reg [6];
	logic [5:0] statusReady_reg;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int s = 0; s < 6; s++) begin
				stableCount_reg[s] <= 8'h00;
			end
			statusReady_reg <= 6'h00;
		end else begin
			for (int s = 0; s < 6; s++) begin
				if (!sourceRunning[s]) begin
					stableCount_reg[s] <= 8'h00;
					statusReady_reg[s] <= 1'b0;
				end else if (stableCount_reg[s] < 8'(STABLE_CYCLES)) begin
					stableCount_reg[s] <= stableCount_reg[s] + 8'h01;
				end else begin
					statusReady_reg[s] <= 1'b1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read channel
	logic rValid_reg;
	logic [31:0] rData_reg;
	logic [1:0] rResp_reg;
	logic [31:0] readMux;

	always_comb begin
		readMux = 32'h00000000;
		case (axiReq.araddr)
			`UPBC_OFS_BUS5: readMux = bus5_reg | {20'h00000, busReady[0], 11'h000};
			`UPBC_OFS_BUS6: readMux = bus6_reg | {20'h00000, busReady[1], 11'h000};
			`UPBC_OFS_BUS7: readMux = (`UPBC_BUS7_RST & 32'hFFFFF7FF)
				| {20'h00000, busReady[2], 11'h000};
			`UPBC_OFS_SLEW: readMux = slew_reg | {31'h00000000, |(~busReady)};
			`UPBC_OFS_STAT: readMux = {23'h000000, statusReady_reg[5:4], 1'b0,
				statusReady_reg[3:2], 1'b0, statusReady_reg[1], 1'b0,
				statusReady_reg[0]};
			`UPBC_OFS_USB_PHASE_LOCKED_LOOP: readMux = usb_phase_locked_loop_reg;
			default: readMux = 32'h00000000;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rValid_reg <= 1'b0;
			rData_reg <= 32'h00000000;
			rResp_reg <= `UPBC_RESP_OKAY;
		end else if (axiReq.arvalid && !rValid_reg) begin
			rValid_reg <= 1'b1;
			rData_reg <= readMux;
			rResp_reg <= isMapped(axiReq.araddr) ? `UPBC_RESP_OKAY : `UPBC_RESP_SLVERR;
		end else if (axiReq.rready) begin
			rValid_reg <= 1'b0;
		end
	end

	assign axiRsp.awready = !awFull_reg && !bValid_reg;
	assign axiRsp.wready = !wFull_reg && !bValid_reg;
	assign axiRsp.bvalid = bValid_reg;
	assign axiRsp.bresp = bResp_reg;
	assign axiRsp.arready = !rValid_reg;
	assign axiRsp.rvalid = rValid_reg;
	assign axiRsp.rdata = rData_reg;
	assign axiRsp.rresp = rResp_reg;

	////////////////////////////////////////////////////////////////////////
	// Checks
	usb_source_a: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		upllWriteOk && wStrb_reg[3] |=> usbClockSourceSelect == $past(wData_reg[29])
	) else $error("usb source select not taken from write");

	odiv_reserved_a: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		upllWriteOk && initDone_reg && wStrb_reg[3] && isReserved(wData_reg[26:24])
			|=> $stable(pllConfig.outputDivideBy)
	) else $error("reserved output divider code was stored");

	odiv_cfg_a: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		$rose(initDone_reg) |-> usb_phase_locked_loop_reg[26:24] == $past(cfgOutputDividerDefault)
	) else $error("output divider not loaded from configuration");

	lock_block_a: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		upllSel && !unlocked && initDone_reg |=> $stable(usb_phase_locked_loop_reg) ##1 !unlocked
	) else $error("locked write changed usb pll control");

	current_oscillator_select_block_a: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		upllSel && currentOscillatorSelect == `UPBC_CURRENT_OSCILLATOR_SELECT_USB_PHASE_LOCKED_LOOP && initDone_reg
			|=> $stable(usb_phase_locked_loop_reg)
	) else $error("write accepted while usb pll is current oscillator");

	seven_ro_a: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		axiReq.arvalid && !rValid_reg && axiReq.araddr == `UPBC_OFS_BUS7
			|=> rData_reg[15:0] == 16'h8800
	) else $error("seventh bus divider did not read its fixed value");

	reset_type_a: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		$rose(initDone_reg) |-> usbClockSourceSelect
			== (!$past(coldReset) && $past(cfgUsbSourceDefault))
	) else $error("usb source reset value ignores reset type");

	stat_ready_a: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		$rose(statusReady_reg[0]) |-> $past(sourceRunning[0], 2) && $past(sourceRunning[0])
			&& $past(stableCount_reg[0]) == 8'(STABLE_CYCLES)
	) else $error("status ready rose before source was stable");

endmodule : upbc_clock_control

/* hdl/upbc_defs.svh */
// Offsets, field positions, reset values and timing counts of the clock control block
`ifndef UPBC_DEFS_SVH
`define UPBC_DEFS_SVH

`define UPBC_ADDR_W 16
`define UPBC_OFS_BUS5 16'h1340
`define UPBC_OFS_BUS6 16'h1350
`define UPBC_OFS_BUS7 16'h1360
`define UPBC_OFS_SLEW 16'h1380
`define UPBC_OFS_STAT 16'h1390
`define UPBC_OFS_USB_PHASE_LOCKED_LOOP 16'h13A0
`define UPBC_OFS_KEY 16'h13B0

`define UPBC_BUSDIV_ON 15
`define UPBC_BUSDIV_RDY 11
`define UPBC_BUSDIV_W 7
`define UPBC_BUSDIV_RST 32'h00008801
`define UPBC_BUS7_RST 32'h00008800

`define UPBC_USB_PHASE_LOCKED_LOOP_SRC 29
`define UPBC_USB_PHASE_LOCKED_LOOP_ODIV 24
`define UPBC_USB_PHASE_LOCKED_LOOP_MULT 16
`define UPBC_USB_PHASE_LOCKED_LOOP_IDIV 8
`define UPBC_USB_PHASE_LOCKED_LOOP_RANGE 0
`define UPBC_USB_PHASE_LOCKED_LOOP_MASK 32'h277F0707
`define UPBC_USB_PHASE_LOCKED_LOOP_RST 32'h00000000

`define UPBC_SLEW_BUSY 0
`define UPBC_SLEW_MASK 32'h000F0706
`define UPBC_SLEW_RST 32'h00000000

`define UPBC_CURRENT_OSCILLATOR_SELECT_USB_PHASE_LOCKED_LOOP 3'h1
`define UPBC_KEY1 32'hAA996655
`define UPBC_KEY2 32'h556699AA

`define UPBC_RESP_OKAY 2'h0
`define UPBC_RESP_SLVERR 2'h2

`define UPBC_CLK_NS 50
`define UPBC_STABLE_NS 1000
`define UPBC_STABLE_CYC ((`UPBC_STABLE_NS + `UPBC_CLK_NS - 1) / `UPBC_CLK_NS)

`endif

/* hdl/upbc_pkg.sv */
// Types shared by the clock control block
`include "upbc_defs.svh"
package upbc_pkg;

	typedef struct packed {
		logic awvalid;
		logic [`UPBC_ADDR_W-1:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [`UPBC_ADDR_W-1:0] araddr;
		logic rready;
	} upbc_axi_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} upbc_axi_rsp_t;

	typedef struct packed {
		logic [6:0] multiplier;
		logic [2:0] inputDivider;
		logic [2:0] inputRange;
		logic [5:0] outputDivideBy;
	} upbc_pll_cfg_t;

	typedef enum logic [1:0] {
		LOCKED,
		KEY_ONE_SEEN,
		UNLOCKED
	} upbc_unlock_state_t;

endpackage : upbc_pkg

/* hdl/upbc_unlock.sv */
// Two-key unlock sequence guarding the protected control register
`include "upbc_defs.svh"
module upbc_unlock
	import upbc_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic keyWrite,
	input wire logic [31:0] keyData,
	input wire logic consume,
	output logic unlocked
);
	upbc_unlock_state_t state_reg;

	////////////////////////////////////////////////////////////////////////
	// Sequence tracker
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= LOCKED;
		end else begin
			case (state_reg)
				LOCKED: begin
					if (keyWrite && keyData == `UPBC_KEY1) begin
						state_reg <= KEY_ONE_SEEN;
					end
				end
				KEY_ONE_SEEN: begin
					if (keyWrite) begin
						state_reg <= (keyData == `UPBC_KEY2) ? UNLOCKED : LOCKED;
					end
				end
				UNLOCKED: begin
					if (consume || keyWrite) begin
						state_reg <= LOCKED;
					end
				end
				default: state_reg <= LOCKED;
			endcase
		end
	end

	assign unlocked = (state_reg == UNLOCKED);

	unlock_keys_a: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		$rose(unlocked) |-> $past(keyWrite && keyData == `UPBC_KEY2)
			&& $past(state_reg == KEY_ONE_SEEN)
	) else $error("unlock reached without the second key");

endmodule : upbc_unlock

/* tb/tb_top.sv */
// Self-checking bench for the USB PLL and bus clock control block
`include "upbc_defs.svh"
module tb_top
	import upbc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	localparam int STABLE = 2;
	logic core_clk;
	logic rst_n;
	upbc_axi_req_t axiReq;
	upbc_axi_rsp_t axiRsp;
	logic [2:0] cfgOutputDividerDefault;
	logic cfgUsbSourceDefault;
	logic coldReset;
	logic [2:0] currentOscillatorSelect;
	logic [5:0] sourceRunning;
	logic usbClockSourceSelect;
	upbc_pll_cfg_t pllConfig;
	logic [2:0] busClockTick;
	int errorCnt = 0;
	int nChecks = 0;
	logic [31:0] rdWord;
	logic [1:0] resp;

	upbc_clock_control #(.STABLE_CYCLES(STABLE)) upbc_clock_control_inst (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.axiReq(axiReq),
		.axiRsp(axiRsp),
		.cfgOutputDividerDefault(cfgOutputDividerDefault),
		.cfgUsbSourceDefault(cfgUsbSourceDefault),
		.coldReset(coldReset),
		.currentOscillatorSelect(currentOscillatorSelect),
		.sourceRunning(sourceRunning),
		.usbClockSourceSelect(usbClockSourceSelect),
		.pllConfig(pllConfig),
		.busClockTick(busClockTick)
	);

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic closeOut();
		$display("checks %0d errors %0d", nChecks, errorCnt);
		if (errorCnt == 0 && nChecks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : closeOut

	task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
		nChecks++;
		if (got !== exp) begin
			errorCnt++;
			$display("[ERR] %0t word got %h expected %h", $time, got, exp);
		end
	endtask : check_word

	task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
		nChecks++;
		if (got !== exp) begin
			errorCnt++;
			$display("[ERR] %0t response got %h expected %h", $time, got, exp);
		end
	endtask : check_resp

	// Write with both channels offered together; sentinel response on a hang
	task automatic axi_write(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
			output logic [1:0] r);
		int n;
		logic awDone;
		logic wDone;
		n = 0;
		awDone = 1'b0;
		wDone = 1'b0;
		r = 2'h3;
		axiReq.awvalid <= 1'b1;
		axiReq.awaddr <= a;
		axiReq.wvalid <= 1'b1;
		axiReq.wdata <= d;
		axiReq.wstrb <= s;
		axiReq.bready <= 1'b1;
		while (n < 200) begin
			@(posedge core_clk);
			n++;
			if (awDone && wDone && axiRsp.bvalid === 1'b1) begin
				r = axiRsp.bresp;
				break;
			end
			if (!awDone && axiRsp.awready === 1'b1) begin
				awDone = 1'b1;
				axiReq.awvalid <= 1'b0;
			end
			if (!wDone && axiRsp.wready === 1'b1) begin
				wDone = 1'b1;
				axiReq.wvalid <= 1'b0;
			end
		end
		axiReq.bready <= 1'b0;
		@(posedge core_clk);
	endtask : axi_write

	task automatic axi_read(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		logic arDone;
		n = 0;
		arDone = 1'b0;
		d = 'x;
		r = 2'h3;
		axiReq.arvalid <= 1'b1;
		axiReq.araddr <= a;
		axiReq.rready <= 1'b1;
		while (n < 200) begin
			@(posedge core_clk);
			n++;
			if (arDone && axiRsp.rvalid === 1'b1) begin
				d = axiRsp.rdata;
				r = axiRsp.rresp;
				break;
			end
			if (!arDone && axiRsp.arready === 1'b1) begin
				arDone = 1'b1;
				axiReq.arvalid <= 1'b0;
			end
		end
		axiReq.rready <= 1'b0;
		@(posedge core_clk);
	endtask : axi_read

	task automatic reg_wr(input logic [15:0] a, input logic [31:0] d);
		logic [1:0] r;
		axi_write(a, d, 4'hF, r);
		check_resp(r, `UPBC_RESP_OKAY);
	endtask : reg_wr

	task automatic reg_check(input logic [15:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0] r;
		axi_read(a, d, r);
		check_resp(r, `UPBC_RESP_OKAY);
		check_word(d, exp);
	endtask : reg_check

	task automatic unlocked_usb_phase_locked_loop(input logic [31:0] d);
		reg_wr(`UPBC_OFS_KEY, `UPBC_KEY1);
		reg_wr(`UPBC_OFS_KEY, `UPBC_KEY2);
		reg_wr(`UPBC_OFS_USB_PHASE_LOCKED_LOOP, d);
	endtask : unlocked_usb_phase_locked_loop

	// Cycles between two tick pulses of one bus divider
	task automatic tick_period(input int idx, input int exp);
		int n;
		n = 0;
		while (busClockTick[idx] !== 1'b1 && n < 400) begin
			@(posedge core_clk);
			n++;
		end
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (busClockTick[idx] !== 1'b1 && n < 400);
		check_word(32'(n), 32'(exp));
	endtask : tick_period

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge core_clk);
		errorCnt++;
		$display("[ERR] %0t watchdog expired", $time);
		closeOut();
	end

	initial begin
		logic [2:0] cw;
		logic [2:0] kept;
		logic [31:0] w;
		axiReq = '0;
		rst_n = 1'b0;
		cfgOutputDividerDefault = 3'h3;
		cfgUsbSourceDefault = 1'b1;
		coldReset = 1'b1;
		currentOscillatorSelect = 3'h0;
		sourceRunning = 6'h00;
		repeat (4) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge core_clk);
		// Reset values after a cold reset
		reg_check(`UPBC_OFS_STAT, 32'h00000000);
		reg_check(`UPBC_OFS_USB_PHASE_LOCKED_LOOP, 32'h03000000);
		check_word({31'h0, usbClockSourceSelect}, 32'h0);
		check_word({26'h0, pllConfig.outputDivideBy}, 32'd8);
		repeat (10) @(posedge core_clk);
		reg_check(`UPBC_OFS_BUS5, `UPBC_BUSDIV_RST);
		reg_check(`UPBC_OFS_BUS6, `UPBC_BUSDIV_RST);
		reg_check(`UPBC_OFS_BUS7, `UPBC_BUS7_RST);
		reg_check(`UPBC_OFS_SLEW, `UPBC_SLEW_RST);
		// Status follows running sources
		sourceRunning <= 6'h3F;
		repeat (10) @(posedge core_clk);
		reg_check(`UPBC_OFS_STAT, 32'h000001B5);
		sourceRunning <= 6'h05;
		repeat (3) @(posedge core_clk);
		reg_check(`UPBC_OFS_STAT, 32'h00000011);
		// Protected write without keys, then every divider code
		reg_wr(`UPBC_OFS_USB_PHASE_LOCKED_LOOP, 32'h00000000);
		reg_check(`UPBC_OFS_USB_PHASE_LOCKED_LOOP, 32'h03000000);
		kept = 3'h3;
		for (int c = 0; c < 8; c++) begin
			cw = 3'(c);
			if (cw >= 3'h1 && cw <= 3'h5) kept = cw;
			w = {2'h0, cw[0], 2'h0, cw, 1'b0, 7'h10, 5'h0, 3'h1, 5'h0, 3'h2};
			unlocked_usb_phase_locked_loop(w);
			reg_check(`UPBC_OFS_USB_PHASE_LOCKED_LOOP, {w[31:27], kept, w[23:0]});
			check_word({26'h0, pllConfig.outputDivideBy}, 32'h1 << kept);
			check_word({31'h0, usbClockSourceSelect}, {31'h0, cw[0]});
			check_word({25'h0, pllConfig.multiplier}, 32'h10);
			check_word({29'h0, pllConfig.inputDivider}, 32'h1);
			check_word({29'h0, pllConfig.inputRange}, 32'h2);
		end
		currentOscillatorSelect <= `UPBC_CURRENT_OSCILLATOR_SELECT_USB_PHASE_LOCKED_LOOP;
		unlocked_usb_phase_locked_loop(32'h00000000);
		reg_check(`UPBC_OFS_USB_PHASE_LOCKED_LOOP, 32'h25100102);
		currentOscillatorSelect <= 3'h0;
		// Read-only seventh divider and divider settling
		reg_wr(`UPBC_OFS_BUS7, 32'h0000807F);
		reg_check(`UPBC_OFS_BUS7, `UPBC_BUS7_RST);
		reg_wr(`UPBC_OFS_BUS5, 32'h0000807F);
		reg_check(`UPBC_OFS_BUS5, 32'h0000807F);
		reg_check(`UPBC_OFS_SLEW, 32'h00000001);
		repeat (300) @(posedge core_clk);
		reg_check(`UPBC_OFS_BUS5, 32'h0000887F);
		tick_period(0, 128);
		axi_write(`UPBC_OFS_BUS6, 32'hFFFF0005, 4'h1, resp);
		check_resp(resp, `UPBC_RESP_OKAY);
		repeat (50) @(posedge core_clk);
		reg_check(`UPBC_OFS_BUS6, 32'h00008805);
		tick_period(1, 6);
		tick_period(2, 1);
		reg_wr(`UPBC_OFS_SLEW, 32'hFFFFFFFF);
		reg_check(`UPBC_OFS_SLEW, `UPBC_SLEW_MASK);
		// Unmapped place
		axi_write(16'h1370, 32'hFFFFFFFF, 4'hF, resp);
		check_resp(resp, `UPBC_RESP_SLVERR);
		axi_read(16'h1370, rdWord, resp);
		check_resp(resp, `UPBC_RESP_SLVERR);
		check_word(rdWord, 32'h0);
		// Warm reset takes the configured source default
		rst_n <= 1'b0;
		coldReset <= 1'b0;
		cfgOutputDividerDefault <= 3'h5;
		repeat (4) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge core_clk);
		reg_check(`UPBC_OFS_USB_PHASE_LOCKED_LOOP, 32'h25000000);
		check_word({31'h0, usbClockSourceSelect}, 32'h1);
		check_word({26'h0, pllConfig.outputDivideBy}, 32'd32);
		repeat (10) @(posedge core_clk);
		reg_check(`UPBC_OFS_BUS5, `UPBC_BUSDIV_RST);
		closeOut();
	end

endmodule : tb_top
